/* File: rtl/uiflf_pkg.sv */
// Purpose: Shared constants for the UART interrupt, FIFO control and
//          line format register block.
// Assumes: 64-entry FIFOs, so levels fit in seven bits.
// Notes:   Register indices sit on the narrow register port.
package uiflf_pkg;
	localparam int REG_AW = 3;
	localparam int LVL_W = 7;
	localparam logic [REG_AW-1:0] IDENT_FIFO_ADDR = 3'h2;
	localparam logic [REG_AW-1:0] FORMAT_ADDR = 3'h3;
	localparam logic [7:0] FORMAT_RESET = 8'h00;
	localparam logic [1:0] TRIG_SEL_RESET = 2'h0;
	localparam int FC_EN = 0;
	localparam int FC_RX_RST = 1;
	localparam int FC_TX_RST = 2;
	localparam int FC_BLOCK_MODE = 3;
	localparam int FEAT_ENH = 4;
	localparam int IER_TX = 1;
	localparam int IER_XOFF = 5;
	localparam int IER_RTS = 6;
	localparam int IER_CTS = 7;
	localparam logic [5:0] ID_NONE = 6'h01;
	localparam logic [5:0] ID_LINE = 6'h06;
	localparam logic [5:0] ID_RX_DATA = 6'h04;
	localparam logic [5:0] ID_RX_TMO = 6'h0C;
	localparam logic [5:0] ID_TX_EMPTY = 6'h02;
	localparam logic [5:0] ID_MODEM = 6'h00;
	localparam logic [5:0] ID_FLOW_CHAR = 6'h10;
	localparam logic [5:0] ID_FLOW_PIN = 6'h20;
	localparam logic [LVL_W-1:0] RX_TRIG_A [4] = '{7'h01, 7'h04, 7'h08,
		7'h0E};
	localparam logic [LVL_W-1:0] TX_TRIG_A = 7'h01;
	localparam logic [LVL_W-1:0] RX_TRIG_B [4] = '{7'h08, 7'h10, 7'h18,
		7'h1C};
	localparam logic [LVL_W-1:0] TX_TRIG_B [4] = '{7'h10, 7'h08, 7'h18,
		7'h1E};
	localparam logic [LVL_W-1:0] RX_TRIG_C [4] = '{7'h08, 7'h10, 7'h38,
		7'h3C};
	localparam logic [LVL_W-1:0] TX_TRIG_C [4] = '{7'h08, 7'h10, 7'h20,
		7'h38};
	localparam logic [3:0] WLEN_BASE = 4'h5;
	localparam logic [2:0] STOP_HALVES_1 = 3'h2;
	localparam logic [2:0] STOP_HALVES_1P5 = 3'h3;
	localparam logic [2:0] STOP_HALVES_2 = 3'h4;
	localparam logic [1:0] WLEN_5_CODE = 2'h0;
endpackage

/* File: rtl/uiflf_fmt_if.sv */
// Purpose: Carries line format control and frame format results between
//          the register block and its frame format helper.
// Assumes: One instance per direction.
// Notes:   The ctl side owns the raw format bits and frame boundaries.
`timescale 1ns/1ps
interface uiflf_fmt_if;
	logic [5:0] cfg;
	logic frame_start;
	logic [7:0] data;
	logic rx_bit;
	logic [3:0] wlen;
	logic [2:0] stop_halves;
	logic par_en;
	logic par_bit;
	logic par_err;
	modport ctl (output cfg, frame_start, data, rx_bit,
		input wlen, stop_halves, par_en, par_bit, par_err);
	modport fmt (input cfg, frame_start, data, rx_bit,
		output wlen, stop_halves, par_en, par_bit, par_err);
endinterface

/* File: rtl/uiflf_frame_fmt.sv */
// Purpose: Holds the frame format used by one shifter and computes its
//          parity bit and parity check.
// Assumes: frame_start pulses once as each character frame begins.
// Notes:   Format changes wait for the next frame boundary.
`timescale 1ns/1ps
module uiflf_frame_fmt (
	input wire logic clk_i,
	input wire logic resetn_i,
	uiflf_fmt_if.fmt f
);
	import uiflf_pkg::*;

	logic [5:0] act;
	logic [5:0] next_act;
	logic [3:0] next_wlen;
	logic [2:0] next_stop;
	logic next_par_bit;
	logic next_par_err;
	logic [7:0] mask;
	logic ones;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_act = f.frame_start ? f.cfg : act; // R25
		next_wlen = WLEN_BASE + {2'h0, next_act[1:0]}; // R18
		if (!next_act[2]) begin
			next_stop = STOP_HALVES_1; // R19
		end else if (next_act[1:0] == WLEN_5_CODE) begin
			next_stop = STOP_HALVES_1P5; // R19
		end else begin
			next_stop = STOP_HALVES_2; // R19
		end
		mask = 8'hFF >> (4'h8 - next_wlen);
		ones = ^(f.data & mask);
		if (next_act[5]) begin
			next_par_bit = ~next_act[4]; // R22
		end else begin
			next_par_bit = next_act[4] ? ones : ~ones; // R21
		end
		next_par_err = next_act[3] && (f.rx_bit != next_par_bit); // R20
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			act <= FORMAT_RESET[5:0];
			f.wlen <= WLEN_BASE;
			f.stop_halves <= STOP_HALVES_1;
			f.par_en <= 1'b0;
			f.par_bit <= 1'b0;
			f.par_err <= 1'b0;
		end else begin
			act <= next_act;
			f.wlen <= next_wlen;
			f.stop_halves <= next_stop;
			f.par_en <= next_act[3]; // R20
			f.par_bit <= next_par_bit;
			f.par_err <= next_par_err;
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_fmt_hold;
		@(posedge clk_i) disable iff (!resetn_i)
		!f.frame_start ##1 !f.frame_start |-> $stable(f.wlen);
	endproperty
	a_fmt_hold: assert property (p_fmt_hold) // R25
		else $error("Frame format changed inside a frame.");

	property p_stop_len;
		@(posedge clk_i) disable iff (!resetn_i)
		f.frame_start && f.cfg[2] |=> f.stop_halves ==
			((f.wlen == WLEN_BASE) ? STOP_HALVES_1P5 : STOP_HALVES_2);
	endproperty
	a_stop_len: assert property (p_stop_len) // R19
		else $error("Stop length does not match word length.");

	property p_force_par;
		@(posedge clk_i) disable iff (!resetn_i)
		f.frame_start && f.cfg[5] |=> f.par_bit == !$past(f.cfg[4]);
	endproperty
	a_force_par: assert property (p_force_par) // R22
		else $error("Forced parity bit has the wrong value.");
endmodule

/* File: rtl/uiflf_top.sv */
// Purpose: Interrupt identification, FIFO control and line format
//          registers of one UART channel.
// Assumes: Pending inputs for line status, receive and modem sources are
//          already gated by their own enables.
// Notes:   Reads and writes of the registers take one clock each.
`timescale 1ns/1ps

// Overview of operation
// R1 - Identification bit 0 low when any interrupt pending, high otherwise.
// R2 - Identification bits 3:1 encode sources of levels one to four.
// R3 - Only the highest priority pending source is reported, levels 1 to 7.
// R4 - Bit 4 flags a flow character match, only with enhanced features.
// R5 - Flow character source clears on read; special also on next char.
// R6 - A status bit tells whether Xoff or Xon was seen last.
// R7 - Bit 5 flags a rising flow pin, only with enhanced features.
// R8 - Bits 7:6 read 11 when FIFOs enabled, 00 when disabled.
// R9 - FIFO enable bit must be set in the write or others are ignored.
// R10 - Receive FIFO reset bit clears receive pointers then self-clears.
// R11 - Transmit FIFO reset bit clears transmit pointers then self-clears.
// R12 - Block transfer mode bit is stored but has no effect.
// R13 - Transmit interrupt when level falls below trigger or empties.
// R14 - Transmit trigger bits are writable only with enhanced features.
// R15 - Both directions share one trigger table from feature control.
// R16 - Table 00 gives receive 1, 4, 8, 14 and transmit 1.
// R17 - Tables 01 and 10 fixed sets; table 11 uses programmed levels.
// R18 - Format bits 1:0 choose word length 5 to 8.
// R19 - Format bit 2 chooses one, one and a half, or two stop bits.
// R20 - Format bit 3 enables parity generation and checking.
// R21 - Format bit 4 chooses odd or even parity.
// R22 - Format bit 5 forces parity to the inverse of bit 4.
// R23 - Reading identification clears a pending transmit interrupt.
// R24 - FIFO reset acts within one clock and levels read empty after.
// R25 - Format changes apply from the next character frame.
module uiflf_top (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [uiflf_pkg::REG_AW-1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [7:0] enhanced_feature_reg_i,
	input wire logic [7:0] feature_trigger_control_i,
	input wire logic [7:0] ier_i,
	input wire logic line_int_i,
	input wire logic rx_rdy_int_i,
	input wire logic rx_tmo_int_i,
	input wire logic msr_int_i,
	input wire logic msr_rd_i,
	input wire logic [uiflf_pkg::LVL_W-1:0] tx_count_i,
	input wire logic [uiflf_pkg::LVL_W-1:0] rx_prog_trig_i,
	input wire logic [uiflf_pkg::LVL_W-1:0] tx_prog_trig_i,
	input wire logic xoff_det_i,
	input wire logic xon_det_i,
	input wire logic special_det_i,
	input wire logic rx_char_i,
	input wire logic flow_rise_i,
	input wire logic tx_frame_start_i,
	input wire logic [7:0] tx_data_i,
	input wire logic rx_frame_start_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_par_bit_i,
	output logic int_pending_o,
	output logic fifo_en_o,
	output logic rx_fifo_rst_o,
	output logic tx_fifo_rst_o,
	output logic dma_mode_o,
	output logic [uiflf_pkg::LVL_W-1:0] rx_trig_o,
	output logic [uiflf_pkg::LVL_W-1:0] tx_trig_o,
	output logic last_flow_char_status_o,
	output logic [3:0] tx_wlen_o,
	output logic [2:0] tx_stop_halves_o,
	output logic tx_par_en_o,
	output logic tx_par_bit_o,
	output logic [3:0] rx_wlen_o,
	output logic [2:0] rx_stop_halves_o,
	output logic rx_par_en_o,
	output logic rx_par_err_o
);
	import uiflf_pkg::*;

	logic [1:0] rst_sync;
	logic rst_n;
	logic [7:0] line_format, next_line_format;
	logic [1:0] rx_sel, next_rx_sel, tx_sel, next_tx_sel;
	logic next_fifo_en, next_rx_rst, next_tx_rst, next_dma;
	logic tx_flag, next_tx_flag, tx_filled, next_tx_filled;
	logic [LVL_W-1:0] tx_prev, next_rx_trig, next_tx_trig;
	logic xflag, next_xflag, xspecial, next_xspecial;
	logic fflag, next_fflag, next_last_xoff;
	logic [7:0] next_rdata;
	logic [5:0] src_code;
	logic src_tx, src_x, src_f, any_src, ident_rd, fc_wr, fmt_wr, fc_wr_d;
	logic tx_below, tx_was_below, tx_evt;

	uiflf_fmt_if tx_if ();
	uiflf_fmt_if rx_if ();

	////////////////////////////////////////////////////////////////////////
	// The first stage only feeds the second, so release is glitch free.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	////////////////////////////////////////////////////////////////////////
	assign ident_rd = reg_rd_i && (reg_addr_i == IDENT_FIFO_ADDR);
	assign fc_wr = reg_wr_i && (reg_addr_i == IDENT_FIFO_ADDR);
	assign fmt_wr = reg_wr_i && (reg_addr_i == FORMAT_ADDR);
	assign src_tx = tx_flag && ier_i[IER_TX];
	assign src_x = xflag && enhanced_feature_reg_i[FEAT_ENH]
		&& ier_i[IER_XOFF]; // R4
	assign src_f = fflag && enhanced_feature_reg_i[FEAT_ENH]
		&& (ier_i[IER_RTS] || ier_i[IER_CTS]); // R7

	always_comb begin
		any_src = 1'b1;
		if (line_int_i) begin // R3
			src_code = ID_LINE; // R2
		end else if (rx_rdy_int_i) begin
			src_code = ID_RX_DATA; // R2
		end else if (rx_tmo_int_i) begin
			src_code = ID_RX_TMO; // R2
		end else if (src_tx) begin
			src_code = ID_TX_EMPTY; // R2
		end else if (msr_int_i) begin
			src_code = ID_MODEM;
		end else if (src_x) begin
			src_code = ID_FLOW_CHAR; // R4
		end else if (src_f) begin
			src_code = ID_FLOW_PIN; // R7
		end else begin
			src_code = ID_NONE; // R1
			any_src = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Table selection comes only from feature control, so a later receive trigger
	// write, or a transmit one with enhanced features, lands in the shared table.
	always_comb begin
		unique case (feature_trigger_control_i[7:6]) // R15
			2'h0: begin
				next_rx_trig = RX_TRIG_A[rx_sel]; // R16
				next_tx_trig = TX_TRIG_A; // R16
			end
			2'h1: begin
				next_rx_trig = RX_TRIG_B[rx_sel]; // R17
				next_tx_trig = TX_TRIG_B[tx_sel]; // R17
			end
			2'h2: begin
				next_rx_trig = RX_TRIG_C[rx_sel]; // R17
				next_tx_trig = TX_TRIG_C[tx_sel]; // R17
			end
			2'h3: begin
				next_rx_trig = rx_prog_trig_i; // R17
				next_tx_trig = tx_prog_trig_i; // R17
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	assign tx_below = tx_count_i < tx_trig_o;
	assign tx_was_below = tx_prev < tx_trig_o;
	assign tx_evt = fifo_en_o
		? ((tx_below && !tx_was_below && tx_filled)
		|| (tx_count_i == '0 && tx_prev != '0 && !tx_filled)) // R13
		: (tx_count_i == '0 && tx_prev != '0);

	always_comb begin
		next_line_format = fmt_wr ? reg_wdata_i : line_format;
		next_fifo_en = fifo_en_o;
		next_rx_rst = 1'b0; // R10
		next_tx_rst = 1'b0; // R11
		next_dma = dma_mode_o;
		next_rx_sel = rx_sel;
		next_tx_sel = tx_sel;
		if (fc_wr) begin
			next_fifo_en = reg_wdata_i[FC_EN]; // R9
			if (reg_wdata_i[FC_EN]) begin // R9
				next_rx_rst = reg_wdata_i[FC_RX_RST]; // R10 R24
				next_tx_rst = reg_wdata_i[FC_TX_RST]; // R11 R24
				next_dma = reg_wdata_i[FC_BLOCK_MODE]; // R12
				next_rx_sel = reg_wdata_i[7:6];
				if (enhanced_feature_reg_i[FEAT_ENH]) begin
					next_tx_sel = reg_wdata_i[5:4]; // R14
				end
			end
		end
		// Hardware events win over a clearing read in the same cycle.
		next_tx_filled = (tx_evt || tx_fifo_rst_o) ? 1'b0
			: (tx_filled || tx_count_i > tx_trig_o);
		next_tx_flag = tx_evt || (tx_flag
			&& !(ident_rd && src_code == ID_TX_EMPTY)); // R23
		next_xflag = xoff_det_i || xon_det_i || special_det_i
			|| (xflag && !(ident_rd && src_code == ID_FLOW_CHAR)
			&& !(xspecial && rx_char_i)); // R5
		next_xspecial = special_det_i
			|| (xspecial && !xoff_det_i && !xon_det_i);
		next_fflag = flow_rise_i || (fflag && !msr_rd_i); // R7
		next_last_xoff = xoff_det_i ? 1'b1
			: (xon_det_i ? 1'b0 : last_flow_char_status_o); // R6
		next_rdata = 8'h00;
		if (ident_rd) begin
			next_rdata = {{2{fifo_en_o}}, src_code}; // R1 R8
		end else if (reg_rd_i && reg_addr_i == FORMAT_ADDR) begin
			next_rdata = line_format;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			line_format <= FORMAT_RESET;
			fifo_en_o <= 1'b0;
			rx_fifo_rst_o <= 1'b0;
			tx_fifo_rst_o <= 1'b0;
			dma_mode_o <= 1'b0;
			rx_sel <= TRIG_SEL_RESET;
			tx_sel <= TRIG_SEL_RESET;
			rx_trig_o <= RX_TRIG_A[0];
			tx_trig_o <= TX_TRIG_A;
			tx_prev <= '0;
			tx_filled <= 1'b0;
			tx_flag <= 1'b0;
			xflag <= 1'b0;
			xspecial <= 1'b0;
			fflag <= 1'b0;
			last_flow_char_status_o <= 1'b0;
			reg_rdata_o <= 8'h00;
			int_pending_o <= 1'b0;
		end else begin
			line_format <= next_line_format;
			fifo_en_o <= next_fifo_en;
			rx_fifo_rst_o <= next_rx_rst;
			tx_fifo_rst_o <= next_tx_rst;
			dma_mode_o <= next_dma;
			rx_sel <= next_rx_sel;
			tx_sel <= next_tx_sel;
			rx_trig_o <= next_rx_trig;
			tx_trig_o <= next_tx_trig;
			tx_prev <= tx_count_i;
			tx_filled <= next_tx_filled;
			tx_flag <= next_tx_flag;
			xflag <= next_xflag;
			xspecial <= next_xspecial;
			fflag <= next_fflag;
			last_flow_char_status_o <= next_last_xoff;
			reg_rdata_o <= next_rdata;
			int_pending_o <= any_src; // R1
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign tx_if.cfg = line_format[5:0];
	assign tx_if.frame_start = tx_frame_start_i;
	assign tx_if.data = tx_data_i;
	assign tx_if.rx_bit = 1'b0;
	assign rx_if.cfg = line_format[5:0];
	assign rx_if.frame_start = rx_frame_start_i;
	assign rx_if.data = rx_data_i;
	assign rx_if.rx_bit = rx_par_bit_i;

	uiflf_frame_fmt u_tx_fmt (.clk_i(clk_i), .resetn_i(rst_n), .f(tx_if));
	uiflf_frame_fmt u_rx_fmt (.clk_i(clk_i), .resetn_i(rst_n), .f(rx_if));

	assign tx_wlen_o = tx_if.wlen;
	assign tx_stop_halves_o = tx_if.stop_halves;
	assign tx_par_en_o = tx_if.par_en;
	assign tx_par_bit_o = tx_if.par_bit;
	assign rx_wlen_o = rx_if.wlen;
	assign rx_stop_halves_o = rx_if.stop_halves;
	assign rx_par_en_o = rx_if.par_en;
	assign rx_par_err_o = rx_if.par_err;

	////////////////////////////////////////////////////////////////////////
	property p_id_idle;
		@(posedge clk_i) disable iff (!rst_n)
		ident_rd && !any_src |=> reg_rdata_o[5:0] == ID_NONE;
	endproperty
	a_id_idle: assert property (p_id_idle) // R1
		else $error("Idle identification read not 01.");

	property p_id_line;
		@(posedge clk_i) disable iff (!rst_n)
		ident_rd && line_int_i |=> reg_rdata_o[5:0] == ID_LINE;
	endproperty
	a_id_line: assert property (p_id_line) // R3
		else $error("Line status did not take top priority.");

	property p_fifo_bits;
		@(posedge clk_i) disable iff (!rst_n)
		ident_rd |=> reg_rdata_o[7:6] == {2{$past(fifo_en_o)}};
	endproperty
	a_fifo_bits: assert property (p_fifo_bits) // R8
		else $error("FIFO status bits disagree with enable.");

	property p_fc_ignore;
		@(posedge clk_i) disable iff (!rst_n)
		fc_wr && !reg_wdata_i[FC_EN] |=> !fifo_en_o && !rx_fifo_rst_o
			&& !tx_fifo_rst_o && $stable(rx_sel);
	endproperty
	a_fc_ignore: assert property (p_fc_ignore) // R9
		else $error("FIFO control acted without enable bit.");

	property p_rx_rst;
		@(posedge clk_i) disable iff (!rst_n)
		fc_wr && reg_wdata_i[FC_EN] && reg_wdata_i[FC_RX_RST]
			|=> rx_fifo_rst_o ##1 (!rx_fifo_rst_o || fc_wr_d);
	endproperty
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			fc_wr_d <= 1'b0;
		end else begin
			fc_wr_d <= fc_wr;
		end
	end
	a_rx_rst: assert property (p_rx_rst) // R10
		else $error("Receive FIFO reset not a single pulse.");

	property p_tx_sel_lock;
		@(posedge clk_i) disable iff (!rst_n)
		fc_wr && !enhanced_feature_reg_i[FEAT_ENH] |=> $stable(tx_sel);
	endproperty
	a_tx_sel_lock: assert property (p_tx_sel_lock) // R14
		else $error("Transmit trigger changed while locked.");

	property p_table_a;
		@(posedge clk_i) disable iff (!rst_n)
		feature_trigger_control_i[7:6] == 2'h0 |=> tx_trig_o == TX_TRIG_A;
	endproperty
	a_table_a: assert property (p_table_a) // R16
		else $error("Table A transmit trigger not 1.");

	property p_tx_clear;
		@(posedge clk_i) disable iff (!rst_n)
		ident_rd && src_code == ID_TX_EMPTY && !tx_evt |=> !tx_flag;
	endproperty
	a_tx_clear: assert property (p_tx_clear) // R23
		else $error("Transmit interrupt survived identification read.");
endmodule

/* File: test/uiflf_peer.sv */
// Purpose: Remote serial sender that frames received characters for the
//          receive side of the register block.
// Assumes: Calls start just after a rising clock edge.
// Notes:   A frame can carry a deliberately wrong parity bit.
`timescale 1ns/1ps
module uiflf_peer (
	input wire logic clk_i,
	output logic frame_start_o,
	output logic char_o,
	output logic [7:0] data_o,
	output logic par_bit_o
);
	initial begin
		frame_start_o = 1'b0;
		char_o = 1'b0;
		data_o = 8'h00;
		par_bit_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic send(input logic [7:0] c, input logic [7:0] f,
		input logic bad);
		frame_start_o <= 1'b1;
		char_o <= 1'b1;
		data_o <= c;
		// Mark or space when forced, else even or odd over the word.
		par_bit_o <= bad ^ (f[5] ? ~f[4] : (f[4] ? ^c : ~^c));
		@(posedge clk_i);
		frame_start_o <= 1'b0;
		char_o <= 1'b0;
		@(posedge clk_i);
	endtask
endmodule

/* File: test/tb_uart_irq_fifo_line_format.sv */
// Purpose: Self-checking bench for the interrupt, FIFO control and line
//          format registers.
// Assumes: Outputs read at an edge show the state left by the edge before.
// Notes:   Parity is checked on 8-bit words only.
`timescale 1ns/1ps
module tb_uart_irq_fifo_line_format;
	import uiflf_pkg::*;
	localparam logic [7:0] RXT [12] = '{8'h01, 8'h04, 8'h08, 8'h0E, 8'h08,
		8'h10, 8'h18, 8'h1C, 8'h08, 8'h10, 8'h38, 8'h3C};
	localparam logic [7:0] TXT [12] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h10,
		8'h08, 8'h18, 8'h1E, 8'h08, 8'h10, 8'h20, 8'h38};
	localparam logic [7:0] CODE [7] = '{8'h06, 8'h04, 8'h0C, 8'h02, 8'h00,
		8'h10, 8'h20};
	localparam logic [7:0] PMODE [5] = '{8'h0B, 8'h1B, 8'h2B, 8'h3B, 8'h03};
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [REG_AW-1:0] reg_addr_i = '0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] enhanced_feature_reg = 8'h10;
	logic [7:0] feature_trigger_control = 8'h00;
	logic [7:0] ier = 8'hE2;
	logic [3:0] lv = 4'h0;
	logic [5:0] ev = 6'h00;
	logic [LVL_W-1:0] tx_count = 7'h05;
	logic [7:0] tx_data = 8'h00;
	logic [7:0] reg_rdata_o, rx_data;
	logic [7:0] rx_cnt = 8'h00;
	logic [7:0] tx_cnt = 8'h00;
	logic rx_fs, rx_char, rx_par, int_pending, fifo_en, rx_rst, tx_rst;
	logic dma, flow_last, tx_pen, tx_pbit, rx_pen, rx_perr;
	logic [LVL_W-1:0] rx_trig, tx_trig;
	logic [3:0] tx_wlen, rx_wlen;
	logic [2:0] tx_stop, rx_stop;
	int bad_count = 0;
	int total_checks = 0;
	int cycles = 0;

	uiflf_top i_dut (.clk_i(clk_i), .resetn_i(resetn_i),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.enhanced_feature_reg_i(enhanced_feature_reg), .feature_trigger_control_i(feature_trigger_control),
		.ier_i(ier), .line_int_i(lv[0]), .rx_rdy_int_i(lv[1]),
		.rx_tmo_int_i(lv[2]), .msr_int_i(lv[3]), .msr_rd_i(ev[5]),
		.tx_count_i(tx_count), .rx_prog_trig_i(7'h2A),
		.tx_prog_trig_i(7'h15), .xoff_det_i(ev[0]), .xon_det_i(ev[1]),
		.special_det_i(ev[2]), .rx_char_i(rx_char), .flow_rise_i(ev[3]),
		.tx_frame_start_i(ev[4]), .tx_data_i(tx_data),
		.rx_frame_start_i(rx_fs), .rx_data_i(rx_data),
		.rx_par_bit_i(rx_par), .int_pending_o(int_pending),
		.fifo_en_o(fifo_en), .rx_fifo_rst_o(rx_rst), .tx_fifo_rst_o(tx_rst),
		.dma_mode_o(dma), .rx_trig_o(rx_trig), .tx_trig_o(tx_trig),
		.last_flow_char_status_o(flow_last), .tx_wlen_o(tx_wlen),
		.tx_stop_halves_o(tx_stop), .tx_par_en_o(tx_pen),
		.tx_par_bit_o(tx_pbit), .rx_wlen_o(rx_wlen),
		.rx_stop_halves_o(rx_stop), .rx_par_en_o(rx_pen),
		.rx_par_err_o(rx_perr));
	uiflf_peer i_peer (.clk_i(clk_i), .frame_start_o(rx_fs),
		.char_o(rx_char), .data_o(rx_data), .par_bit_o(rx_par));

	////////////////////////////////////////////////////////////////////////
	always #4 clk_i = ~clk_i;
	// Counting high cycles proves each reset is a single-cycle pulse.
	always @(posedge clk_i) begin
		rx_cnt <= rx_cnt + 8'(rx_rst === 1'b1);
		tx_cnt <= tx_cnt + 8'(tx_rst === 1'b1);
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count++;
			test_done();
		end
	end

	task automatic test_done();
		if (bad_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [REG_AW-1:0] a, input logic [7:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rdchk(input logic [REG_AW-1:0] a, input logic [7:0] exp,
		input string what);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(what, reg_rdata_o, exp);
		@(posedge clk_i);
	endtask
	task automatic pulse(input int i);
		ev[i] <= 1'b1;
		@(posedge clk_i);
		ev <= 6'h00;
		@(posedge clk_i);
	endtask
	function automatic logic par_of(input logic [7:0] f, input logic [7:0] d);
		return f[5] ? ~f[4] : (f[4] ? ^d : ~^d);
	endfunction

	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] d;
		logic [7:0] wl;
		logic [7:0] sh;
		wl = 8'h05;
		sh = 8'h02;
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("rx_trig", {1'b0, rx_trig}, 8'h01);
		chk("tx_wlen", {4'h0, tx_wlen}, 8'h05);
		rdchk(IDENT_FIFO_ADDR, 8'h01, "ident");
		rdchk(FORMAT_ADDR, 8'h00, "line_format");
		wr(IDENT_FIFO_ADDR, 8'h07);
		repeat (2) @(posedge clk_i);
		chk("fifo_en", {7'h0, fifo_en}, 8'h01);
		chk("rx_rst_cnt", rx_cnt, 8'h01);
		chk("tx_rst_cnt", tx_cnt, 8'h01);
		rdchk(IDENT_FIFO_ADDR, 8'hC1, "ident");
		wr(IDENT_FIFO_ADDR, 8'h0E);
		@(posedge clk_i);
		chk("fifo_en", {7'h0, fifo_en}, 8'h00);
		chk("rx_rst_cnt", rx_cnt, 8'h01);
		rdchk(IDENT_FIFO_ADDR, 8'h01, "ident");
		wr(IDENT_FIFO_ADDR, 8'h09);
		@(posedge clk_i);
		chk("dma", {7'h0, dma}, 8'h01);
		chk("tx_rst_cnt", tx_cnt, 8'h01);
		for (int t = 0; t < 4; t++) begin
			for (int c = 0; c < 4; c++) begin
				feature_trigger_control <= 8'(t << 6);
				wr(IDENT_FIFO_ADDR, 8'(c * 8'h50 + 1));
				@(posedge clk_i);
				chk("rx_trig", {1'b0, rx_trig},
					(t == 3) ? 8'h2A : RXT[t * 4 + c]);
				chk("tx_trig", {1'b0, tx_trig},
					(t == 3) ? 8'h15 : TXT[t * 4 + c]);
			end
		end
		enhanced_feature_reg <= 8'h00;
		feature_trigger_control <= 8'h40;
		wr(IDENT_FIFO_ADDR, 8'h01);
		@(posedge clk_i);
		chk("tx_trig", {1'b0, tx_trig}, 8'h1E);
		chk("rx_trig", {1'b0, rx_trig}, 8'h08);
		enhanced_feature_reg <= 8'h10;
		wr(IDENT_FIFO_ADDR, 8'h00);
		lv <= 4'hF;
		tx_count <= 7'h00;
		pulse(0);
		chk("flow_last", {7'h0, flow_last}, 8'h01);
		pulse(1);
		chk("flow_last", {7'h0, flow_last}, 8'h00);
		pulse(0);
		pulse(3);
		for (int k = 0; k < 7; k++) begin
			chk("pending", {7'h0, int_pending}, 8'h01);
			rdchk(IDENT_FIFO_ADDR, CODE[k], "ident");
			if (k < 3)
				lv[k] <= 1'b0;
			if (k == 4)
				lv[3] <= 1'b0;
			if (k == 6)
				pulse(5);
			else
				repeat (2) @(posedge clk_i);
		end
		rdchk(IDENT_FIFO_ADDR, 8'h01, "ident");
		pulse(2);
		@(posedge clk_i);
		chk("pending", {7'h0, int_pending}, 8'h01);
		i_peer.send(8'h00, 8'h00, 1'b0);
		@(posedge clk_i);
		chk("pending", {7'h0, int_pending}, 8'h00);
		// With FIFOs on, a fill above 16 then a drop below it must interrupt.
		wr(IDENT_FIFO_ADDR, 8'h01);
		tx_count <= 7'h20;
		repeat (2) @(posedge clk_i);
		tx_count <= 7'h08;
		repeat (2) @(posedge clk_i);
		rdchk(IDENT_FIFO_ADDR, 8'hC2, "ident");
		rdchk(IDENT_FIFO_ADDR, 8'hC1, "ident");
		for (int j = 0; j < 8; j++) begin
			wr(FORMAT_ADDR, 8'(j));
			chk("tx_wlen", {4'h0, tx_wlen}, wl);
			pulse(4);
			i_peer.send(8'h00, 8'h00, 1'b0);
			wl = 8'h05 + 8'(j % 4);
			sh = (j < 4) ? 8'h02 : ((j == 4) ? 8'h03 : 8'h04);
			chk("tx_wlen", {4'h0, tx_wlen}, wl);
			chk("rx_wlen", {4'h0, rx_wlen}, wl);
			chk("tx_stop", {5'h0, tx_stop}, sh);
			chk("rx_stop", {5'h0, rx_stop}, sh);
		end
		rdchk(FORMAT_ADDR, 8'h07, "line_format");
		for (int m = 0; m < 5; m++) begin
			wr(FORMAT_ADDR, PMODE[m]);
			pulse(4);
			i_peer.send(8'h00, PMODE[m], 1'b0);
			for (int b = 0; b < 2; b++) begin
				d = (b == 1) ? 8'h03 : 8'h01;
				tx_data <= d;
				i_peer.send(d, PMODE[m], b[0]);
				@(posedge clk_i);
				chk("tx_par_en", {7'h0, tx_pen}, {7'h0, PMODE[m][3]});
				chk("rx_par_en", {7'h0, rx_pen}, {7'h0, PMODE[m][3]});
				if (PMODE[m][3])
					chk("tx_par_bit", {7'h0, tx_pbit},
						{7'h0, par_of(PMODE[m], d)});
				chk("rx_par_err", {7'h0, rx_perr},
					{7'h0, PMODE[m][3] & b[0]});
			end
		end
		test_done();
	end
endmodule
